// file: rtl/lic_led_indicator_control.sv
// LED indicator control: blink slots, override and status-driven LED logic
`default_nettype none
module lic_led_indicator_control
    import lic_pkg::*;
#(
    parameter int TICK_CYCLES = lic_pkg::LIC_TICK_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        link_up,
    input  wire logic        speed_100,
    input  wire logic        full_duplex,
    input  wire logic        tx_active,
    input  wire logic        rx_active,
    input  wire logic        collision,
    input  wire logic        duty_invert,
    input  wire logic        collision_fast,
    input  wire logic        heavy_rate_en,
    input  wire logic [4:0]  heavy_traffic_threshold,
    output logic             led_on
);
    import lic_pkg::*;

    // Selects of the blink slot used by the active blink condition
    typedef enum logic [3:0] {
        LIC_SRC_NONE  = 4'h1,
        LIC_SRC_SLOT0 = 4'h2,
        LIC_SRC_SLOT1 = 4'h4,
        LIC_SRC_SLOT2 = 4'h8
    } lic_src_t;

    logic [15:0] led_blink_rate_select;
    logic [15:0] led_one_behaviour_control;
    logic [15:0] tick_cnt;
    logic        tick;
    logic [3:0]  slot_blink;
    logic [3:0]  slot_code [4];
    logic [9:0]  window_ms;
    logic [9:0]  tx_busy_ms;
    logic [9:0]  rx_busy_ms;
    logic        heavy_tx;
    logic        heavy_rx;
    logic [4:0]  stretch_ms;
    logic        next_led;
    lic_src_t    src;

    // Control field views
    logic        override_enable;
    logic [1:0]  override_state;
    logic        activity_blink_independent;
    logic        full_duplex_light_en;
    logic        half_duplex_light_en;
    logic        transmit_activity_blink_en;
    logic        receive_activity_blink_en;
    logic        transmit_activity_light_en;
    logic        receive_activity_light_en;
    logic        fast_speed_light_en;
    logic        slow_speed_light_en;
    logic        collision_blink_en;
    logic        fast_speed_blink_en;
    logic        slow_speed_blink_en;

    assign override_enable            = led_one_behaviour_control[LIC_B_OVR_EN];
    assign override_state             = led_one_behaviour_control[
                                            LIC_B_OVR_HI:LIC_B_OVR_LO];
    assign activity_blink_independent = led_one_behaviour_control[
                                            LIC_B_ACT_IND];
    assign full_duplex_light_en       = led_one_behaviour_control[LIC_B_FDX_ON];
    assign half_duplex_light_en       = led_one_behaviour_control[LIC_B_HDX_ON];
    assign transmit_activity_blink_en = led_one_behaviour_control[
                                            LIC_B_TX_BLINK];
    assign receive_activity_blink_en  = led_one_behaviour_control[
                                            LIC_B_RX_BLINK];
    assign transmit_activity_light_en = led_one_behaviour_control[LIC_B_TX_ON];
    assign receive_activity_light_en  = led_one_behaviour_control[LIC_B_RX_ON];
    assign fast_speed_light_en        = led_one_behaviour_control[
                                            LIC_B_FAST_ON];
    assign slow_speed_light_en        = led_one_behaviour_control[
                                            LIC_B_SLOW_ON];
    assign collision_blink_en         = led_one_behaviour_control[
                                            LIC_B_COL_BLINK];
    assign fast_speed_blink_en        = led_one_behaviour_control[
                                            LIC_B_FAST_BLINK];
    assign slow_speed_blink_en        = led_one_behaviour_control[
                                            LIC_B_SLOW_BLINK];

    // Rate codes per slot
    assign slot_code[0] = led_blink_rate_select[LIC_SLOT0_LSB +: 4];
    assign slot_code[1] = led_blink_rate_select[LIC_SLOT1_LSB +: 4];
    assign slot_code[2] = led_blink_rate_select[LIC_SLOT2_LSB +: 4];
    assign slot_code[3] = led_blink_rate_select[LIC_SLOT3_LSB +: 4];

    // Register writes; bit 0 of the control register is reserved, reads 0
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            led_blink_rate_select     <= LIC_RATE_RESET;
            led_one_behaviour_control <= LIC_CTRL_RESET;
        end else if (reg_wr) begin
            if (reg_addr == LIC_ADDR_RATE) begin
                led_blink_rate_select <= reg_wdata;
            end
            if (reg_addr == LIC_ADDR_CTRL) begin
                led_one_behaviour_control <= reg_wdata & LIC_CTRL_WMASK;
            end
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads 0
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                LIC_ADDR_RATE:   reg_rdata <= led_blink_rate_select;
                LIC_ADDR_CTRL:   reg_rdata <= led_one_behaviour_control;
                LIC_ADDR_STATUS: reg_rdata <= {11'h000, heavy_rx, heavy_tx,
                                               (stretch_ms != 5'h00),
                                               link_up, led_on};
                default:         reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // 1 ms base tick; everything slower counts ticks to keep counters small
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else if (tick_cnt >= 16'(TICK_CYCLES - 1)) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick     <= 1'b0;
        end
    end

    // One free-running blink phase per slot; off share comes first
    generate
        for (genvar s = 0; s < 4; s++) begin : g_slot
            logic [13:0] phase_ms;
            logic [13:0] period_ms;
            logic [13:0] off_ms;

            assign period_ms = lic_period_ms(slot_code[s]);
            assign off_ms    = lic_off_ms(slot_code[s]);

            // Wrap also when a smaller code shortens the period mid-count
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    phase_ms <= 14'h0000;
                end else if (tick) begin
                    if (phase_ms >= period_ms - 14'h0001) begin
                        phase_ms <= 14'h0000;
                    end else begin
                        phase_ms <= phase_ms + 14'h0001;
                    end
                end
            end

            // Inversion swaps which part of the period is lit
            assign slot_blink[s] = (phase_ms >= off_ms) ^ duty_invert;
        end
    endgenerate

    // Heavy traffic: busy milliseconds per direction over a 1 s window
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            window_ms  <= 10'h000;
            tx_busy_ms <= 10'h000;
            rx_busy_ms <= 10'h000;
            heavy_tx   <= 1'b0;
            heavy_rx   <= 1'b0;
        end else if (tick) begin
            if (window_ms >= 10'(LIC_WINDOW_MS - 1)) begin
                window_ms  <= 10'h000;
                tx_busy_ms <= 10'h000;
                rx_busy_ms <= 10'h000;
                heavy_tx   <= 16'(tx_busy_ms) >
                              16'(heavy_traffic_threshold) *
                              16'(LIC_TRAFFIC_MS);
                heavy_rx   <= 16'(rx_busy_ms) >
                              16'(heavy_traffic_threshold) *
                              16'(LIC_TRAFFIC_MS);
            end else begin
                window_ms  <= window_ms + 10'h001;
                tx_busy_ms <= tx_busy_ms + {9'h000, tx_active};
                rx_busy_ms <= rx_busy_ms + {9'h000, rx_active};
            end
        end
    end

    // Activity stretch: reload on activity, count down per tick.
    // Loading one extra tick guarantees at least the full 10 ms lit.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stretch_ms <= 5'h00;
        end else if (link_up && ((tx_active && transmit_activity_light_en) ||
                                 (rx_active && receive_activity_light_en))) begin
            stretch_ms <= 5'(LIC_STRETCH_MS + 1);
        end else if (tick && stretch_ms != 5'h00) begin
            stretch_ms <= stretch_ms - 5'h01;
        end
    end

    // Steady-on and blink condition decode
    logic on_cond;
    logic act_gate;
    logic act_blink;
    logic col_blink;
    logic speed_blink;
    logic heavy;

    always_comb begin
        on_cond = link_up &&
                  ((full_duplex_light_en && full_duplex) ||
                   (half_duplex_light_en && !full_duplex) ||
                   (fast_speed_light_en && speed_100) ||
                   (slow_speed_light_en && !speed_100));
        // Independent mode or the LIC_B_OVR_LO bit blinks from off too; else needs a lit state
        act_gate = activity_blink_independent ||
                   led_one_behaviour_control[LIC_B_OVR_LO] ||
                   on_cond || (stretch_ms != 5'h00);
        act_blink = link_up && act_gate &&
                    ((tx_active && transmit_activity_blink_en) ||
                     (rx_active && receive_activity_blink_en));
        col_blink = link_up && collision && collision_blink_en;
        speed_blink = link_up &&
                      ((fast_speed_blink_en && speed_100) ||
                       (slow_speed_blink_en && !speed_100));
        heavy = heavy_tx || heavy_rx;
    end

    // Blink source priority: collision, then activity, then speed
    always_comb begin
        if (col_blink) begin
            src = collision_fast ? LIC_SRC_SLOT2 : LIC_SRC_SLOT1;
        end else if (act_blink) begin
            src = (heavy_rate_en && heavy) ? LIC_SRC_SLOT0
                                           : LIC_SRC_SLOT2;
        end else if (speed_blink) begin
            src = LIC_SRC_SLOT2;
        end else begin
            src = LIC_SRC_NONE;
        end
    end

    // Final LED level; override replaces every status-driven term
    always_comb begin
        if (override_enable) begin
            case (override_state)
                LIC_OVR_OFF:   next_led = 1'b0;
                LIC_OVR_ON:    next_led = 1'b1;
                LIC_OVR_SLOT1: next_led = slot_blink[1];
                LIC_OVR_SLOT2: next_led = slot_blink[2];
                default:       next_led = 1'b0;
            endcase
        end else begin
            case (src)
                LIC_SRC_SLOT0: next_led = slot_blink[0];
                LIC_SRC_SLOT1: next_led = slot_blink[1];
                LIC_SRC_SLOT2: next_led = slot_blink[2];
                LIC_SRC_NONE:  next_led = on_cond ||
                                          (stretch_ms != 5'h00);
                default:       next_led = 1'b0;
            endcase
        end
    end

    // LED output register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            led_on <= 1'b0;
        end else begin
            led_on <= next_led;
        end
    end

endmodule : lic_led_indicator_control
`default_nettype wire

// file: rtl/lic_pkg.sv
// Constants, register map and blink-rate table for the LED indicator block
`default_nettype none
package lic_pkg;

    // Register addresses (16-bit register index space)
    localparam logic [15:0] LIC_ADDR_RATE   = 16'h40C2;
    localparam logic [15:0] LIC_ADDR_CTRL   = 16'h40C3;
    localparam logic [15:0] LIC_ADDR_STATUS = 16'h40C4;

    // Reset values and control register write mask
    localparam logic [15:0] LIC_RATE_RESET = 16'hEC75;
    localparam logic [15:0] LIC_CTRL_RESET = 16'h0310;
    localparam logic [15:0] LIC_CTRL_WMASK = 16'hFFFE;

    // Rate register field positions (low bit of each 4-bit code)
    localparam int LIC_SLOT0_LSB = 12;
    localparam int LIC_SLOT1_LSB = 8;
    localparam int LIC_SLOT2_LSB = 4;
    localparam int LIC_SLOT3_LSB = 0;

    // Control register bit positions
    localparam int LIC_B_OVR_EN     = 15;
    localparam int LIC_B_OVR_HI     = 14;
    localparam int LIC_B_OVR_LO     = 13;
    localparam int LIC_B_ACT_IND    = 12;
    localparam int LIC_B_FDX_ON     = 11;
    localparam int LIC_B_HDX_ON     = 10;
    localparam int LIC_B_TX_BLINK   = 9;
    localparam int LIC_B_RX_BLINK   = 8;
    localparam int LIC_B_TX_ON      = 7;
    localparam int LIC_B_RX_ON      = 6;
    localparam int LIC_B_FAST_ON    = 5;
    localparam int LIC_B_SLOW_ON    = 4;
    localparam int LIC_B_COL_BLINK  = 3;
    localparam int LIC_B_FAST_BLINK = 2;
    localparam int LIC_B_SLOW_BLINK = 1;

    // Override state encodings
    localparam logic [1:0] LIC_OVR_OFF    = 2'h0;
    localparam logic [1:0] LIC_OVR_ON     = 2'h1;
    localparam logic [1:0] LIC_OVR_SLOT1  = 2'h2;
    localparam logic [1:0] LIC_OVR_SLOT2  = 2'h3;

    // Timing: clock period and the 1 ms base tick
    localparam int LIC_CLK_PERIOD_NS = 100;
    localparam int LIC_TICK_NS       = 1000000;
    localparam int LIC_TICK_CYCLES   = LIC_TICK_NS / LIC_CLK_PERIOD_NS;
    localparam int LIC_WINDOW_MS     = 1000;
    localparam int LIC_STRETCH_MS    = 10;
    localparam int LIC_TRAFFIC_MS    = 42;

    // Blink period in ms for each rate code
    function automatic logic [13:0] lic_period_ms(input logic [3:0] code);
        case (code)
            4'h0:    lic_period_ms = 14'd10000;
            4'h1:    lic_period_ms = 14'd9400;
            4'h2:    lic_period_ms = 14'd8000;
            4'h3:    lic_period_ms = 14'd7400;
            4'h4:    lic_period_ms = 14'd6000;
            4'h5:    lic_period_ms = 14'd5000;
            4'h6:    lic_period_ms = 14'd4000;
            4'h7:    lic_period_ms = 14'd3000;
            4'hB:    lic_period_ms = 14'd500;
            4'hC:    lic_period_ms = 14'd333;
            4'hD:    lic_period_ms = 14'd166;
            4'hE:    lic_period_ms = 14'd125;
            4'hF:    lic_period_ms = 14'd100;
            default: lic_period_ms = 14'd1000;
        endcase
    endfunction : lic_period_ms

    // Off share in ms at the start of each period
    function automatic logic [13:0] lic_off_ms(input logic [3:0] code);
        case (code)
            4'h0:    lic_off_ms = 14'd600;
            4'h1:    lic_off_ms = 14'd658;
            4'h2:    lic_off_ms = 14'd640;
            4'h3:    lic_off_ms = 14'd666;
            4'h4:    lic_off_ms = 14'd660;
            4'h5:    lic_off_ms = 14'd300;
            4'h6:    lic_off_ms = 14'd320;
            4'h7:    lic_off_ms = 14'd330;
            4'hB:    lic_off_ms = 14'd250;
            4'hC:    lic_off_ms = 14'd166;
            4'hD:    lic_off_ms = 14'd83;
            4'hE:    lic_off_ms = 14'd62;
            4'hF:    lic_off_ms = 14'd50;
            default: lic_off_ms = 14'd160;
        endcase
    endfunction : lic_off_ms

endpackage : lic_pkg
`default_nettype wire

// file: test/lic_checker.sv
// Checker for register reads and LED level of the indicator block
`default_nettype none
module lic_checker
    import lic_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        link_up,
    input  wire logic        speed_100,
    input  wire logic        tx_active,
    input  wire logic        rx_active,
    input  wire logic        collision,
    input  wire logic        led_on
);
    localparam logic [15:0] HOLD_MIN = 16'(10 * TICK_CYCLES);
    localparam logic [15:0] HOLD_MAX = 16'(12 * TICK_CYCLES);
    logic [15:0] sh_rate;
    logic [15:0] sh_ctrl;
    logic [15:0] act_age;
    logic        calm;

    // Shadows mirror software writes so reads can be predicted
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sh_rate <= 16'hEC75;
            sh_ctrl <= 16'h0310;
        end else if (reg_wr && reg_addr == 16'h40C2) begin
            sh_rate <= reg_wdata;
        end else if (reg_wr && reg_addr == 16'h40C3) begin
            sh_ctrl <= reg_wdata & 16'hFFFE;
        end
    end

    // Cycles since last stretching activity; saturates so it never wraps
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            act_age <= 16'hFFFF;
        end else if (link_up && ((tx_active && sh_ctrl[7]) ||
                                 (rx_active && sh_ctrl[6]))) begin
            act_age <= 16'h0000;
        end else if (act_age != 16'hFFFF) begin
            act_age <= act_age + 16'h0001;
        end
    end

    // No blink cause present and no override
    assign calm = !tx_active && !rx_active && !collision &&
                  sh_ctrl[2:1] == 2'h0 && !sh_ctrl[15];

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data not zero outside read answer");
    chk_rate_read: assert property (
        reg_rd && reg_addr == 16'h40C2 |=> reg_rdata == $past(sh_rate))
        else $error("rate register read mismatch");
    chk_ctrl_read: assert property (
        reg_rd && reg_addr == 16'h40C3 |=> reg_rdata == $past(sh_ctrl))
        else $error("control register read mismatch");
    chk_unmapped_read: assert property (reg_rd && reg_addr != 16'h40C2 &&
        reg_addr != 16'h40C3 && reg_addr != 16'h40C4 |=> reg_rdata == 16'h0)
        else $error("unmapped read not zero");
    chk_force_dark: assert property (
        sh_ctrl[15] && sh_ctrl[14:13] == 2'h0 |=> !led_on)
        else $error("forced off but LED lit");
    chk_force_lit: assert property (
        sh_ctrl[15] && sh_ctrl[14:13] == 2'h1 |=> led_on)
        else $error("forced on but LED dark");
    chk_slow_light: assert property (
        (calm && sh_ctrl[4] && link_up && !speed_100) [*2] |=> led_on)
        else $error("10M link light missing");
    chk_fast_light: assert property (
        (calm && sh_ctrl[5] && link_up && speed_100) [*2] |=> led_on)
        else $error("100M link light missing");
    chk_link_dark: assert property ((!sh_ctrl[15] && !link_up &&
        act_age > HOLD_MAX) [*2] |=> !led_on)
        else $error("LED lit without link");
    chk_stretch_hold: assert property (
        !sh_ctrl[15] && sh_ctrl[9:8] == 2'h0 && sh_ctrl[3:1] == 3'h0 &&
        act_age >= 16'h0003 && act_age <= HOLD_MIN |-> led_on)
        else $error("activity stretch ended early");
endmodule : lic_checker

bind lic_led_indicator_control lic_checker #(.TICK_CYCLES(TICK_CYCLES))
    u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
           .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
           .reg_rdata(reg_rdata), .link_up(link_up), .speed_100(speed_100),
           .tx_active(tx_active), .rx_active(rx_active),
           .collision(collision), .led_on(led_on));
`default_nettype wire

// file: test/lic_led_model.sv
// Behavioural status LED that measures lit time over a window
`default_nettype none
module lic_led_model (
    input  wire logic        ref_clk,
    input  wire logic        led_on,
    input  wire logic        count_en,
    output logic      [15:0] lit_cycles
);
    timeunit 1ns;
    timeprecision 1ns;
    // A lamp keeps no state; only lit cycles are tallied, cleared between
    always_ff @(posedge ref_clk) begin
        if (!count_en) begin
            lit_cycles <= 16'h0000;
        end else if (led_on === 1'b1) begin
            lit_cycles <= lit_cycles + 16'h0001;
        end
    end
endmodule : lic_led_model
`default_nettype wire

// file: test/tb_led_indicator_control.sv
// Self-checking bench for the LED indicator control block
`default_nettype none
module tb_led_indicator_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
    logic link_up = 1'b0, speed_100 = 1'b0, full_duplex = 1'b0;
    logic tx_active = 1'b0, rx_active = 1'b0, collision = 1'b0;
    logic duty_invert = 1'b0, collision_fast = 1'b0, count_en = 1'b0;
    // Threshold starts above any 1 s busy count, so traffic is never heavy
    logic heavy_rate_en = 1'b0;
    logic [4:0] heavy_traffic_threshold = 5'h1F;
    logic led_on;
    logic [15:0] lit_cycles;
    int err_count = 0;
    int n_compared = 0;

    // 10 MHz reference clock
    always #50 ref_clk = ~ref_clk;

    lic_led_indicator_control #(.TICK_CYCLES(10)) DUT (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .link_up(link_up), .speed_100(speed_100),
        .full_duplex(full_duplex), .tx_active(tx_active),
        .rx_active(rx_active), .collision(collision),
        .duty_invert(duty_invert), .collision_fast(collision_fast),
        .heavy_rate_en(heavy_rate_en),
        .heavy_traffic_threshold(heavy_traffic_threshold),
        .led_on(led_on));

    lic_led_model u_led (.ref_clk(ref_clk), .led_on(led_on),
                         .count_en(count_en), .lit_cycles(lit_cycles));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd_chk

    task automatic led_is(input logic e);
        repeat (4) @(posedge ref_clk);
        #1;
        check({15'h0000, led_on}, {15'h0000, e});
    endtask : led_is

    // Settle a few cycles first so pipeline latency stays out of the window
    task automatic lit(input int n, input logic [15:0] e);
        repeat (4) @(posedge ref_clk);
        count_en <= 1'b1;
        repeat (n) @(posedge ref_clk);
        count_en <= 1'b0;
        #1;
        check(lit_cycles, e);
    endtask : lit

    task automatic t_regs;
        rd_chk(16'h40C2, 16'hEC75);
        rd_chk(16'h40C3, 16'h0310);
        wr(16'h40C3, 16'hFFFF);
        rd_chk(16'h40C3, 16'hFFFE);
        wr(16'h40C5, 16'h1234);
        rd_chk(16'h40C5, 16'h0000);
        wr(16'h40C3, 16'h0310);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_lights;
        link_up <= 1'b1;
        led_is(1'b1);
        speed_100 <= 1'b1;
        led_is(1'b0);
        wr(16'h40C3, 16'h0020);
        led_is(1'b1);
        wr(16'h40C3, 16'h0800);
        full_duplex <= 1'b1;
        led_is(1'b1);
        full_duplex <= 1'b0;
        led_is(1'b0);
        wr(16'h40C3, 16'h0400);
        led_is(1'b1);
        $display("t_lights done");
    endtask : t_lights

    task automatic t_force;
        speed_100 <= 1'b0;
        wr(16'h40C3, 16'h0110);
        led_is(1'b1);
        link_up <= 1'b0;
        wr(16'h40C3, 16'hA000);
        led_is(1'b1);
        link_up <= 1'b1;
        wr(16'h40C3, 16'h8010);
        led_is(1'b0);
        wr(16'h40C3, 16'hC000);
        lit(3330, 16'd1670);
        duty_invert <= 1'b1;
        lit(3330, 16'd1660);
        duty_invert <= 1'b0;
        $display("t_force done");
    endtask : t_force

    // Slot 2 codes with their period and lit share in ms
    task automatic t_rates;
        logic [3:0] codes[3] = '{4'hB, 4'h9, 4'hD};
        int pers[3] = '{500, 1000, 166};
        int ons[3] = '{250, 840, 83};
        wr(16'h40C3, 16'hE000);
        for (int i = 0; i < 3; i++) begin
            wr(16'h40C2, {8'hEF, codes[i], 4'h5});
            repeat (pers[i] * 10) @(posedge ref_clk);
            lit(pers[i] * 10, 16'(ons[i] * 10));
        end
        $display("t_rates done");
    endtask : t_rates

    task automatic t_blinks;
        wr(16'h40C2, 16'hEFD5);
        wr(16'h40C3, 16'h0008);
        collision <= 1'b1;
        repeat (1660) @(posedge ref_clk);
        lit(1000, 16'd500);
        collision_fast <= 1'b1;
        lit(1660, 16'd830);
        collision <= 1'b0;
        wr(16'h40C3, 16'h0002);
        lit(1660, 16'd830);
        wr(16'h40C3, 16'h0004);
        speed_100 <= 1'b1;
        lit(1660, 16'd830);
        speed_100 <= 1'b0;
        wr(16'h40C3, 16'h0310);
        rx_active <= 1'b1;
        lit(1660, 16'd830);
        rx_active <= 1'b0;
        wr(16'h40C3, 16'h0200);
        tx_active <= 1'b1;
        led_is(1'b0);
        wr(16'h40C3, 16'h1200);
        lit(1660, 16'd830);
        tx_active <= 1'b0;
        $display("t_blinks done");
    endtask : t_blinks

    // One short transmit burst must keep the LED lit for 10 ms
    task automatic t_stretch;
        wr(16'h40C3, 16'h0080);
        led_is(1'b0);
        tx_active <= 1'b1;
        @(posedge ref_clk);
        tx_active <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check({15'h0000, led_on}, 16'h0001);
        repeat (95) @(posedge ref_clk);
        #1;
        check({15'h0000, led_on}, 16'h0001);
        repeat (40) @(posedge ref_clk);
        #1;
        check({15'h0000, led_on}, 16'h0000);
        rd_chk(16'h40C4, 16'h0002);
        $display("t_stretch done");
    endtask : t_stretch

    // A transmit burst over a whole window makes activity use slot 0
    task automatic t_heavy;
        heavy_traffic_threshold <= 5'h01;
        heavy_rate_en           <= 1'b1;
        wr(16'h40C3, 16'h1200);
        tx_active <= 1'b1;
        repeat (11000) @(posedge ref_clk);
        lit(1250, 16'd630);
        tx_active <= 1'b0;
        $display("t_heavy done");
    endtask : t_heavy

    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_lights();
        t_force();
        t_rates();
        t_blinks();
        t_stretch();
        t_heavy();
        stop_test();
    end

    // Whole sequence needs about 64000 cycles
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_count++;
        stop_test();
    end
endmodule : tb_led_indicator_control
`default_nettype wire
